// [hdl/vtc_trim_counter.sv]
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Gated low pulse over 200us increments
// - Gated high pulse over 200us decrements
// - Pulses under 20us never count
// - First pulse after power-up never counts; a held program one still writes
// - Counter saturates at both ends
// - Counter drives the current DAC code
// - Counter loads from memory at power-on
// - Program band starts a memory write
// - Programming finishes within 100ms
// - Programming stores present counter value
// - Gate low when a pulse ends inhibits counting
module vtc_trim_counter #(
    parameter int unsigned PROG_CYCLES = vtc_pkg::PROG_CYC
) (
    input  wire logic                clock,
    input  wire logic                srst,
    input  wire vtc_pkg::vtc_band_t  trim_control_pin,
    input  wire logic                count_gate,
    input  wire logic [6:0]          nvm_rd_data,
    output var  logic [6:0]          sink_current_output,
    output var  vtc_pkg::vtc_nvm_wr_t nvm_wr,
    output var  logic                prog_busy
);
    // Pulse tracker state
    vtc_pkg::vtc_state_t   st_q, st_d;
    // Band of the pulse in progress; program band wins once seen
    vtc_pkg::vtc_band_t    pb_q, pb_d;
    // Pulse length timer, saturating
    // Twelve bits reach past the qualify count with room to spare
    logic [11:0]           tmr_q, tmr_d;
    // Set once the first pulse has been swallowed
    // Only reset clears it, as only power-on can
    logic                  armed_q, armed_d;
    // Counter holds memory value after load
    logic                  loaded_q, loaded_d;
    // Trim counter, the setting minus one
    logic [6:0]            cnt_q, cnt_d;
    // Programming cycle timer
    // Wide enough for the full programming time at any sane clock
    logic [31:0]           ptm_q, ptm_d;
    // Programming cycle running; freezes the counter
    logic                  busy_q, busy_d;
    // Next memory write request; the output flop is the only copy
    vtc_pkg::vtc_nvm_wr_t  wr_d;

    // Timer at or past a cycle threshold
    // Timer is widened so the compare is done at 32 bits
    function automatic logic tmr_ge(input logic [11:0] t,
                                    input int unsigned n);
        tmr_ge = ({20'h0, t} >= n);
    endfunction : tmr_ge

    // Saturating one-step move of the trim code
    // Ends hold their value so repeated requests never wrap
    // Shared by both count directions
    function automatic logic [6:0] step_code(input logic [6:0] c,
                                             input logic       up);
        if (up) begin
            // Count up unless already at the top
            step_code = (c == vtc_pkg::CODE_MAX) ? c : c + 7'h01;
        end else begin
            // Count down unless already at the bottom
            step_code = (c == vtc_pkg::CODE_MIN) ? c : c - 7'h01;
        end
    endfunction : step_code

    // Pulse tracking, counting and programming
    // One block so every next value sees the same pulse end
    always_comb begin
        // Hold everything by default
        st_d     = st_q;
        pb_d     = pb_q;
        tmr_d    = tmr_q;
        armed_d  = armed_q;
        // Load happens once, in the first cycle out of reset
        loaded_d = 1'b1;
        cnt_d    = cnt_q;
        ptm_d    = ptm_q;
        busy_d   = busy_q;
        // Write strobe idles low; data tracks the counter
        wr_d     = '{wr: 1'b0, data: cnt_q};
        // Memory value taken as it stands after reset
        // power-on load
        if (!loaded_q) begin
            cnt_d = nvm_rd_data;
        end
        // Timer saturates so long pulses stay qualified
        if (tmr_q != 12'hfff) begin
            tmr_d = tmr_q + 12'h001;
        end
        // Pulse tracker
        case (st_q)
            // Pin at mid, waiting for a pulse
            vtc_pkg::VTC_ST_IDLE: begin
                // Any departure from mid starts a pulse
                if (trim_control_pin != vtc_pkg::VTC_BAND_MID) begin
                    st_d  = vtc_pkg::VTC_ST_PULSE;
                    // Remember which way the pulse went
                    pb_d  = trim_control_pin;
                    // First cycle off mid already counts
                    tmr_d = 12'h001;
                end
            end
            // Pin off mid, pulse length being measured
            vtc_pkg::VTC_ST_PULSE: begin
                // A slow edge to program passes through high first
                // program band overrides count band
                if (trim_control_pin == vtc_pkg::VTC_BAND_PROG) begin
                    pb_d = vtc_pkg::VTC_BAND_PROG;
                end
                if (trim_control_pin == vtc_pkg::VTC_BAND_MID) begin
                    // Pulse ended; decide on its length
                    st_d = vtc_pkg::VTC_ST_IDLE;
                    // Comparators may wake in any band, so no count
                    // swallow first pulse
                    armed_d = 1'b1;
                    // One threshold; the 20 to 200us gap is undefined
                    // Gate is looked at only where the pulse ends
                    // qualify at 200us; shorter ones drop
                    if (armed_q && !busy_q && count_gate &&
                        tmr_ge(tmr_q, vtc_pkg::QUAL_CYC)) begin
                        // low pulse counts up, at max holds
                        if (pb_q == vtc_pkg::VTC_BAND_LOW) begin
                            cnt_d = step_code(cnt_q, 1'b1);
                        end
                        // high pulse counts down, at min holds
                        if (pb_q == vtc_pkg::VTC_BAND_HIGH) begin
                            cnt_d = step_code(cnt_q, 1'b0);
                        end
                        // A program band pulse never counts
                    end
                end else if (pb_q == vtc_pkg::VTC_BAND_PROG &&
                             trim_control_pin ==
                             vtc_pkg::VTC_BAND_PROG &&
                             tmr_ge(tmr_q, vtc_pkg::QUAL_CYC) &&
                             !busy_q) begin
                    // Still off mid: a held program level writes
                    // held program level starts a write
                    wr_d   = '{wr: 1'b1, data: cnt_q};
                    busy_d = 1'b1;
                    // Programming time counted from the strobe
                    ptm_d  = 32'h0;
                    // One write per program pulse, however long
                    st_d   = vtc_pkg::VTC_ST_WAIT;
                end
            end
            // Program pulse used; wait for pin to return mid
            vtc_pkg::VTC_ST_WAIT: begin
                // Return to mid ends the pulse without a count
                if (trim_control_pin == vtc_pkg::VTC_BAND_MID) begin
                    st_d    = vtc_pkg::VTC_ST_IDLE;
                    // A program pulse can be the first one; it writes all the same
                    armed_d = 1'b1;
                end
            end
            // Unused code falls back to idle
            default: st_d = vtc_pkg::VTC_ST_IDLE;
        endcase
        // Busy lasts exactly the programming cycle count
        // bounded programming time
        if (busy_q) begin
            ptm_d = ptm_q + 32'h1;
            // Final cycle of the count drops busy
            if (ptm_q >= PROG_CYCLES - 1) begin
                busy_d = 1'b0;
            end
        end
    end

    // Register all state; outputs are flops
    // Sync reset stands in for power-on
    always_ff @(posedge clock) begin
        if (srst) begin
            // Idle, unarmed, and waiting to load the counter
            st_q     <= vtc_pkg::VTC_ST_IDLE;
            pb_q     <= vtc_pkg::VTC_BAND_MID;
            tmr_q    <= 12'h000;
            armed_q  <= 1'b0;
            loaded_q <= 1'b0;
            cnt_q    <= 7'h00;
            ptm_q    <= 32'h0;
            busy_q   <= 1'b0;
        end else begin
            // Next values only; all decisions sit above
            st_q     <= st_d;
            pb_q     <= pb_d;
            tmr_q    <= tmr_d;
            armed_q  <= armed_d;
            loaded_q <= loaded_d;
            cnt_q    <= cnt_d;
            ptm_q    <= ptm_d;
            busy_q   <= busy_d;
        end
    end

    // Fed from the next values so pins agree with the state flops
    // Costs a few duplicate flops but keeps every output registered
    // DAC code straight from counter
    always_ff @(posedge clock) begin
        if (srst) begin
            // Zero code, no write and idle during reset
            sink_current_output <= 7'h00;
            nvm_wr              <= '0;
            prog_busy           <= 1'b0;
        end else begin
            // Code is the setting minus one, 0 to 127
            sink_current_output <= cnt_d;
            nvm_wr              <= wr_d;
            prog_busy           <= busy_d;
        end
    end
endmodule : vtc_trim_counter
`default_nettype wire

// [hdl/vtc_pkg.sv]
package vtc_pkg;
    // Clock rate
    localparam int unsigned CLK_HZ          = 10_000_000;
    // Pulse qualification time, microseconds
    localparam int unsigned QUAL_US         = 200;
    // Reject time for short pulses, microseconds
    localparam int unsigned REJECT_US       = 20;
    // Programming cycle upper bound, milliseconds
    localparam int unsigned PROG_MS         = 100;
    // Cycle counts (least times round down)
    localparam int unsigned QUAL_CYC =
        (QUAL_US * (CLK_HZ / 1_000_000));
    localparam int unsigned REJECT_CYC =
        (REJECT_US * (CLK_HZ / 1_000_000));
    // Longest time rounds down; this is a parameter default
    localparam int unsigned PROG_CYC =
        (PROG_MS * (CLK_HZ / 1_000));
    // Counter geometry
    localparam int unsigned CODE_W          = 7;
    localparam logic [6:0]  CODE_MIN        = 7'h00;
    localparam logic [6:0]  CODE_MAX        = 7'h7f;
    // Width of the pulse timer
    localparam int unsigned TMR_W           = 12;

    // Control pin level bands from the analog comparators
    typedef enum logic [1:0] {
        VTC_BAND_MID  = 2'b00,
        VTC_BAND_LOW  = 2'b01,
        VTC_BAND_HIGH = 2'b11,
        VTC_BAND_PROG = 2'b10
    } vtc_band_t;

    // Pulse tracker states, Gray order
    typedef enum logic [1:0] {
        VTC_ST_IDLE  = 2'b00,
        VTC_ST_PULSE = 2'b01,
        VTC_ST_WAIT  = 2'b11
    } vtc_state_t;

    // Memory write request carrier
    typedef struct packed {
        logic       wr;
        logic [6:0] data;
    } vtc_nvm_wr_t;
endpackage : vtc_pkg

// [dv/vtc_trim_counter_props.sv]
`timescale 1ns/100ps
`default_nettype none
// Port-level checks on the trim counter
module vtc_trim_counter_props #(
    parameter int unsigned PROG_CYCLES = 50
) (
    input wire logic                 clock,
    input wire logic                 srst,
    input wire vtc_pkg::vtc_band_t   trim_control_pin,
    input wire logic                 count_gate,
    input wire logic [6:0]           nvm_rd_data,
    input wire logic [6:0]           sink_current_output,
    input wire vtc_pkg::vtc_nvm_wr_t nvm_wr,
    input wire logic                 prog_busy
);
    int unsigned bc_q; // Busy cycles so far
    logic [2:0]  rh_q; // Recent reset history
    // Reload after reset is a jump, so mask it
    always_ff @(posedge clock) begin
        bc_q <= (srst || !prog_busy) ? 0 : bc_q + 1;
        rh_q <= {rh_q[1:0], srst};
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    a_wr_one_shot: assert property (nvm_wr.wr |=> !nvm_wr.wr)
        else $error("write strobe too long");
    a_wr_starts_busy: assert property (nvm_wr.wr |-> $rose(prog_busy))
        else $error("busy not raised with write");
    a_wr_data_code: assert property (
        nvm_wr.wr |-> nvm_wr.data == sink_current_output)
        else $error("stored data differs from code");
    a_busy_bounded: assert property (
        $fell(prog_busy) |-> bc_q <= PROG_CYCLES && bc_q > 0)
        else $error("busy length wrong");
    a_busy_freeze: assert property (
        prog_busy |=> $stable(sink_current_output))
        else $error("code moved while busy");
    a_gate_blocks: assert property (
        !count_gate && trim_control_pin == vtc_pkg::VTC_BAND_MID &&
        $past(trim_control_pin) != vtc_pkg::VTC_BAND_MID
        |-> ##1 $stable(sink_current_output)[*2])
        else $error("count with gate low");
    a_step_unit: assert property (
        rh_q == 3'h0 && $changed(sink_current_output) |->
        sink_current_output - $past(sink_current_output) inside
        {7'h01, 7'h7f})
        else $error("code step not one");
    a_change_at_mid: assert property (
        rh_q == 3'h0 && $changed(sink_current_output) |->
        $past(trim_control_pin) == vtc_pkg::VTC_BAND_MID)
        else $error("code moved mid pulse");
endmodule : vtc_trim_counter_props
bind vtc_trim_counter vtc_trim_counter_props #(
    .PROG_CYCLES(PROG_CYCLES)
) u_props (
    .clock(clock), .srst(srst), .trim_control_pin(trim_control_pin),
    .count_gate(count_gate), .nvm_rd_data(nvm_rd_data),
    .sink_current_output(sink_current_output), .nvm_wr(nvm_wr),
    .prog_busy(prog_busy));
`default_nettype wire

// [dv/vtc_nvm_model.sv]
`timescale 1ns/100ps
`default_nettype none
// Stored setting; bench presets it
module vtc_nvm_model (
    input  wire logic                 clock,
    input  wire vtc_pkg::vtc_nvm_wr_t nvm_wr,
    output var  logic [6:0]           nvm_rd_data
);
    logic [6:0] mem; // Cell contents
    always @(posedge clock) begin
        if (nvm_wr.wr) begin
            mem <= nvm_wr.data;
        end
    end
    assign nvm_rd_data = mem;
endmodule : vtc_nvm_model
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic                 clock = 1'b0;
    logic                 srst  = 1'b1;
    logic                 gate  = 1'b0;
    logic [6:0]           rd, code;
    logic                 busy;
    vtc_pkg::vtc_nvm_wr_t wr;
    vtc_pkg::vtc_band_t   pin   = vtc_pkg::VTC_BAND_MID;
    int n_errors = 0, checked = 0, seed = 32'hcfa2, exp_code;
    bit armed; // First pulse already seen
    int n_busy = 0, n_wr = 0; // Busy cycles and write strobes seen
    always #50 clock = ~clock;
    vtc_trim_counter #(.PROG_CYCLES(50)) dut (.clock(clock), .srst(srst),
        .trim_control_pin(pin), .count_gate(gate), .nvm_rd_data(rd),
        .sink_current_output(code), .nvm_wr(wr), .prog_busy(busy));
    vtc_nvm_model nvm (.clock(clock), .nvm_wr(wr), .nvm_rd_data(rd));
    // Count busy cycles and write strobes as the design shows them
    always @(posedge clock) begin
        if (busy === 1'b1) n_busy++;
        if (wr.wr === 1'b1) n_wr++;
    end
    task stop_test;
        if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    task chk(string what, logic [6:0] e, logic [6:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    // Gate dropped as power goes, then restart
    task power_on(logic [6:0] e);
        gate <= 1'b0;
        srst <= 1'b1;
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        repeat (4) @(posedge clock);
        armed = 0;
        exp_code = e;
        chk("reload", e, code);
    endtask : power_on
    // One pulse then mid; reference model updates
    task pulse(vtc_pkg::vtc_band_t b, int n, logic g);
        gate <= g;
        pin <= b;
        repeat (n) @(posedge clock);
        pin <= vtc_pkg::VTC_BAND_MID;
        repeat (4) @(posedge clock);
        if (!armed) armed = 1;
        else if (g && n >= 2000 && b == vtc_pkg::VTC_BAND_LOW) begin
            if (exp_code < 127) exp_code++;
        end else if (g && n >= 2000 && b == vtc_pkg::VTC_BAND_HIGH) begin
            if (exp_code > 0) exp_code--;
        end
        chk("code", exp_code[6:0], code);
    endtask : pulse
    initial begin
        nvm.mem = 7'h7d;
        power_on(7'h7d);
        pulse(vtc_pkg::VTC_BAND_LOW, 2100, 1'b1);
        pulse(vtc_pkg::VTC_BAND_LOW, 10 + ($random(seed) & 127), 1'b1);
        pulse(vtc_pkg::VTC_BAND_LOW, 1500, 1'b1);
        repeat (4) pulse(vtc_pkg::VTC_BAND_LOW,
            2050 + ($random(seed) & 63), 1'b1);
        pulse(vtc_pkg::VTC_BAND_HIGH, 2100, 1'b0);
        pulse(vtc_pkg::VTC_BAND_HIGH, 2100, 1'b1);
        pulse(vtc_pkg::VTC_BAND_PROG, 2100, 1'b1);
        repeat (60) @(posedge clock);
        chk("stored", exp_code[6:0], nvm.mem);
        chk("busy cycles", 7'h32, n_busy[6:0]);
        chk("writes", 7'h01, n_wr[6:0]);
        power_on(7'h7e);
        nvm.mem = 7'h01;
        power_on(7'h01);
        repeat (4) pulse(vtc_pkg::VTC_BAND_HIGH, 2100, 1'b1);
        chk("writes", 7'h01, n_wr[6:0]);
        stop_test;
    end
    // Hang guard, about three times the expected run
    initial begin
        repeat (80000) @(posedge clock);
        n_errors++;
        stop_test;
    end
endmodule : tb
`default_nettype wire
